// [verilog/iosbt_pkg.sv]
// Shared constants and types of the board connection test structure
package iosbt_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PINS = 4'h8;
  localparam int CTRL_ALLOW_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_ALLOW_RESET = 1'h1;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_MODE_LSB = 1;
  localparam int STAT_SETTLED_BIT = 3;
  localparam int STAT_PARITY_BIT = 4;
  localparam int STAT_ENABLE_BIT = 5;
  // ****************************************************
  // Pin vector layout
  // ****************************************************
  localparam int PIN_W = 12;
  localparam int P_EN = 0;
  localparam int P_MS0 = 1;
  localparam int P_MS1 = 2;
  localparam int P_NL = 3;
  localparam int P_DRV = 4;
  localparam int P_CSI = 5;
  localparam int P_DSI = 6;
  localparam int P_RST = 7;
  localparam int P_XTAL = 8;
  localparam int P_BCK = 9;
  localparam int P_FRM = 10;
  localparam int P_SF = 11;
  localparam int CHAIN_LSB = P_CSI;
  localparam int CHAIN_W = 7;
  localparam int QUIET_W = 9;
  // ****************************************************
  // Mode pin codes {sel0, sel1, net/line}
  // ****************************************************
  localparam logic [2:0] CODE_PARITY = 3'h5;
  localparam logic [2:0] CODE_DRIVE = 3'h6;
  localparam logic [2:0] CODE_HIZ = 3'h4;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_NS = 8;
  localparam int SETTLE_NS = 800;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W = 7;
  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_PARITY = 2'h1,
    MODE_DRIVE = 2'h3,
    MODE_HIZ = 2'h2
  } iosbt_mode_type;
  typedef enum logic [2:0] {
    INIT_IDLE = 3'h0,
    INIT_S1 = 3'h1,
    INIT_S2 = 3'h3,
    INIT_S3 = 3'h2,
    INIT_S4 = 3'h6,
    INIT_S5 = 3'h7,
    INIT_S6 = 3'h5,
    INIT_S7 = 3'h4
  } iosbt_init_type;
  // Clock/frame pair {bit clock, frame} at each init step
  localparam logic [1:0] STEP1 = 2'h0;
  localparam logic [1:0] STEP2 = 2'h2;
  localparam logic [1:0] STEP3 = 2'h0;
  localparam logic [1:0] STEP4 = 2'h1;
  localparam logic [1:0] STEP5 = 2'h3;
  localparam logic [1:0] STEP6 = 2'h1;
  localparam logic [1:0] STEP7 = 2'h2;
endpackage

// [verilog/iosbt_pin_sync.sv]
// Three stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
module iosbt_pin_sync import iosbt_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1, s2, s3, lvl;
  logic [W-1:0] next_lvl;

  // Take a bit only where the last two stages agree
  always_comb begin
    next_lvl = (s2 & s3) | (lvl & (s2 | s3));
  end

  // Register the chain
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  assign level_out = lvl;

  chk_sync_agree: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (s2 == s3) |=> (lvl == $past(s3))) else $error("sync level not taken on agreement");
endmodule

// [verilog/iosbt_parity.sv]
// Exclusive-or chain across the monitored input pins
`timescale 1ns/1ps
module iosbt_parity import iosbt_pkg::*; #(
  parameter int W = CHAIN_W
) (
  input wire logic [W-1:0] bits_in,
  output logic odd_out
);
  logic [W:0] link;

  // One gate per pin, chained in order
  assign link[0] = 1'b0;
  for (genvar i = 0; i < W; i++) begin : g_chain
    assign link[i+1] = link[i] ^ bits_in[i];
  end
  assign odd_out = link[W];
endmodule

// [verilog/iosbt_top.sv]
// Board connection test structure: parity chain, forced drive and float modes
`timescale 1ns/1ps
module iosbt_top import iosbt_pkg::*; (
  input wire logic clock_in,
  input wire logic nrst_in,
  // Avalon-MM slave
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Test and mode pins
  input wire logic test_structure_enable_in,
  input wire logic mode_select_bit0_in,
  input wire logic mode_select_bit1_in,
  input wire logic network_or_line_side_select_in,
  input wire logic test_drive_in,
  // Functional input pins
  input wire logic control_serial_in,
  input wire logic data_serial_in,
  input wire logic master_reset_n_in,
  input wire logic crystal_in,
  input wire logic bit_clock_io_in,
  input wire logic frame_pulse_io_in,
  input wire logic superframe_pulse_io_in,
  // Normal values from the core
  input wire logic normal_data_serial_in,
  input wire logic normal_data_serial_oe_in,
  input wire logic normal_control_serial_in,
  input wire logic normal_control_serial_oe_in,
  input wire logic normal_frame_pulse_low_in,
  input wire logic normal_bit_clock_in,
  input wire logic normal_frame_pulse_in,
  input wire logic normal_superframe_in,
  input wire logic normal_timing_oe_in,
  // Output pins
  output logic data_serial_out,
  output logic data_serial_oe_out,
  output logic control_serial_out,
  output logic control_serial_oe_out,
  output logic frame_pulse_open_drain_out,
  output logic frame_pulse_open_drain_oe_out,
  output logic parity_chain_out,
  output logic parity_chain_oe_out,
  output logic bit_clock_io_out,
  output logic bit_clock_io_oe_out,
  output logic frame_pulse_io_out,
  output logic frame_pulse_io_oe_out,
  output logic superframe_pulse_io_out,
  output logic superframe_pulse_io_oe_out
);
  // ****************************************************
  // Pin capture
  // ****************************************************
  logic [PIN_W-1:0] pin_raw, pin;
  logic odd;

  assign pin_raw = {superframe_pulse_io_in, frame_pulse_io_in, bit_clock_io_in,
                    crystal_in, master_reset_n_in, data_serial_in, control_serial_in,
                    test_drive_in, network_or_line_side_select_in,
                    mode_select_bit1_in, mode_select_bit0_in, test_structure_enable_in};

  iosbt_pin_sync #(.W(PIN_W)) u_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .pin_in(pin_raw),
    .level_out(pin)
  );

  // Chain over every functional input
  iosbt_parity #(.W(CHAIN_W)) u_chain (
    .bits_in(pin[CHAIN_LSB +: CHAIN_W]),
    .odd_out(odd)
  );

  // ****************************************************
  // Init vector tracker
  // ****************************************************
  iosbt_init_type init_st, next_init_st;
  logic armed, next_armed;
  logic quiet;
  logic [1:0] pair;
  logic sw_clear;

  assign quiet = ~|pin[QUIET_W-1:0];
  assign pair = {pin[P_BCK], pin[P_FRM]};

  // Step through the clock/frame pattern with all else low except superframe, which is not watched
  always_comb begin
    next_init_st = init_st;
    next_armed = armed;
    if (sw_clear) begin
      next_armed = 1'b0;
    end
    if (!quiet) begin
      next_init_st = INIT_IDLE;
    end else begin
      case (init_st)
        INIT_IDLE: next_init_st = (pair == STEP1) ? INIT_S1 : INIT_IDLE;
        INIT_S1: begin
          if (pair == STEP2) next_init_st = INIT_S2;
          else if (pair != STEP1) next_init_st = INIT_IDLE;
        end
        INIT_S2: begin
          if (pair == STEP3) next_init_st = INIT_S3;
          else if (pair != STEP2) next_init_st = INIT_IDLE;
        end
        INIT_S3: begin
          if (pair == STEP4) next_init_st = INIT_S4;
          else if (pair != STEP3) next_init_st = INIT_IDLE;
        end
        INIT_S4: begin
          if (pair == STEP5) next_init_st = INIT_S5;
          else if (pair != STEP4) next_init_st = INIT_IDLE;
        end
        INIT_S5: begin
          if (pair == STEP6) next_init_st = INIT_S6;
          else if (pair != STEP5) next_init_st = INIT_IDLE;
        end
        INIT_S6: begin
          if (pair == STEP7) begin
            next_init_st = INIT_S7;
            next_armed = 1'b1;  // Set beats a clearing write
          end else if (pair != STEP6) begin
            next_init_st = (pair == STEP1) ? INIT_S1 : INIT_IDLE;
          end
        end
        INIT_S7: begin
          if (pair != STEP7) next_init_st = (pair == STEP1) ? INIT_S1 : INIT_IDLE;
        end
        default: next_init_st = INIT_IDLE;
      endcase
    end
  end

  // Register tracker state
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      init_st <= INIT_IDLE;
      armed <= 1'b0;
    end else begin
      init_st <= next_init_st;
      armed <= next_armed;
    end
  end

  // ****************************************************
  // Mode decode
  // ****************************************************
  iosbt_mode_type mode;
  logic allow;
  logic [2:0] code;

  assign code = {pin[P_MS0], pin[P_MS1], pin[P_NL]};

  // Enable, init and software allow qualify the select code
  always_comb begin
    mode = MODE_OFF;
    if (pin[P_EN] && armed && allow) begin
      case (code)
        CODE_PARITY: mode = MODE_PARITY;
        CODE_DRIVE: mode = MODE_DRIVE;
        CODE_HIZ: mode = MODE_HIZ;
        default: mode = MODE_OFF;
      endcase
    end
  end

  // ****************************************************
  // Output pin drivers
  // ****************************************************
  logic next_ds, next_ds_oe, next_cs, next_cs_oe;
  logic next_fod, next_fod_oe, next_par, next_par_oe;
  logic next_bck, next_frm, next_sf, next_tim_oe;
  logic drv;

  assign drv = pin[P_DRV];

  // Pick normal, forced or floating values per mode
  always_comb begin
    next_ds = normal_data_serial_in;
    next_ds_oe = normal_data_serial_oe_in;
    next_cs = normal_control_serial_in;
    next_cs_oe = normal_control_serial_oe_in;
    next_fod = 1'b0;
    next_fod_oe = normal_frame_pulse_low_in;
    next_par = 1'b0;
    next_par_oe = 1'b1;
    next_bck = normal_bit_clock_in;
    next_frm = normal_frame_pulse_in;
    next_sf = normal_superframe_in;
    next_tim_oe = normal_timing_oe_in;
    case (mode)
      MODE_PARITY: begin
        next_par = odd;
        next_tim_oe = 1'b0;
      end
      MODE_DRIVE: begin
        next_ds = drv;
        next_ds_oe = 1'b1;
        next_cs = drv;
        next_cs_oe = 1'b1;
        next_fod_oe = ~drv;  // Open drain: released when high
        next_par = drv;
        next_bck = drv;
        next_frm = drv;
        next_sf = drv;
        next_tim_oe = 1'b1;
      end
      MODE_HIZ: begin
        next_ds_oe = 1'b0;
        next_cs_oe = 1'b0;
        next_fod_oe = 1'b0;
        next_par_oe = 1'b0;
        next_tim_oe = 1'b0;
      end
      default: begin
        next_par = 1'b0;
      end
    endcase
  end

  // Register all pin values
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_serial_out <= 1'b0;
      data_serial_oe_out <= 1'b0;
      control_serial_out <= 1'b0;
      control_serial_oe_out <= 1'b0;
      frame_pulse_open_drain_out <= 1'b0;
      frame_pulse_open_drain_oe_out <= 1'b0;
      parity_chain_out <= 1'b0;
      parity_chain_oe_out <= 1'b0;
      bit_clock_io_out <= 1'b0;
      frame_pulse_io_out <= 1'b0;
      superframe_pulse_io_out <= 1'b0;
      bit_clock_io_oe_out <= 1'b0;
      frame_pulse_io_oe_out <= 1'b0;
      superframe_pulse_io_oe_out <= 1'b0;
    end else begin
      data_serial_out <= next_ds;
      data_serial_oe_out <= next_ds_oe;
      control_serial_out <= next_cs;
      control_serial_oe_out <= next_cs_oe;
      frame_pulse_open_drain_out <= next_fod;
      frame_pulse_open_drain_oe_out <= next_fod_oe;
      parity_chain_out <= next_par;
      parity_chain_oe_out <= next_par_oe;
      bit_clock_io_out <= next_bck;
      frame_pulse_io_out <= next_frm;
      superframe_pulse_io_out <= next_sf;
      bit_clock_io_oe_out <= next_tim_oe;
      frame_pulse_io_oe_out <= next_tim_oe;
      superframe_pulse_io_oe_out <= next_tim_oe;
    end
  end

  // ****************************************************
  // Settling timer
  // ****************************************************
  logic [SETTLE_W-1:0] settle, next_settle;
  logic [PIN_W-1:0] pin_last;

  // Reload on any input change, count down to settled
  always_comb begin
    next_settle = settle;
    if (pin != pin_last) begin
      next_settle = SETTLE_W'(SETTLE_CYCLES);
    end else if (settle != '0) begin
      next_settle = settle - 1'b1;
    end
  end

  // Register the timer
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      settle <= '0;
      pin_last <= '0;
    end else begin
      settle <= next_settle;
      pin_last <= pin;
    end
  end

  // ****************************************************
  // Register bus
  // ****************************************************
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic next_allow;
  logic req;

  assign req = read_in | write_in;
  assign waitrequest_out = req & ~ack;
  assign sw_clear = write_in & ack & (address_in == REG_CTRL) & writedata_in[CTRL_CLEAR_BIT];

  // One wait cycle, then answer; unmapped reads give zero
  always_comb begin
    next_ack = req & ~ack;
    next_rdata = rdata;
    next_allow = allow;
    if (read_in && !ack) begin
      next_rdata = '0;
      case (address_in)
        REG_CTRL: next_rdata[CTRL_ALLOW_BIT] = allow;
        REG_STATUS: begin
          next_rdata[STAT_ARMED_BIT] = armed;
          next_rdata[STAT_MODE_LSB +: 2] = mode;
          next_rdata[STAT_SETTLED_BIT] = (settle == '0);
          next_rdata[STAT_PARITY_BIT] = odd;
          next_rdata[STAT_ENABLE_BIT] = pin[P_EN];
        end
        REG_PINS: next_rdata[PIN_W-1:0] = pin;
        default: next_rdata = '0;
      endcase
    end
    if (write_in && ack && address_in == REG_CTRL) begin
      next_allow = writedata_in[CTRL_ALLOW_BIT];
    end
  end

  // Register bus state
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack <= 1'b0;
      rdata <= '0;
      allow <= CTRL_ALLOW_RESET;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      allow <= next_allow;
    end
  end

  assign readdata_out = rdata;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence s_step6;
    quiet && init_st == INIT_S6;
  endsequence
  sequence s_step7;
    quiet && pair == STEP7;
  endsequence

  chk_init_arms: assert property (s_step6 ##0 s_step7 |=> armed)
    else $error("init pattern did not arm");
  chk_mode_gate: assert property (mode != MODE_OFF |-> pin[P_EN] && armed)
    else $error("mode active without enable and init");
  chk_parity_code: assert property (mode == MODE_PARITY |-> code == 3'h5)
    else $error("parity mode on wrong code");
  chk_parity_pin: assert property (mode == MODE_PARITY |=>
    parity_chain_out == ^$past(pin[CHAIN_LSB +: CHAIN_W]) && parity_chain_oe_out)
    else $error("parity pin wrong");
  chk_drive_follow: assert property (mode == MODE_DRIVE |=>
    data_serial_out == $past(drv) && control_serial_out == $past(drv) &&
    bit_clock_io_out == $past(drv) && frame_pulse_open_drain_oe_out == !$past(drv))
    else $error("outputs not following drive pin");
  chk_hiz_float: assert property (mode == MODE_HIZ |=>
    !(data_serial_oe_out | control_serial_oe_out | parity_chain_oe_out |
      frame_pulse_open_drain_oe_out | superframe_pulse_io_oe_out))
    else $error("output driven in float mode");
  chk_normal_pass: assert property (!pin[P_EN] |=>
    data_serial_out == $past(normal_data_serial_in) &&
    bit_clock_io_oe_out == $past(normal_timing_oe_in))
    else $error("normal path disturbed");
  chk_settle_hold: assert property ($changed(pin) |=> (settle != '0) [*8])
    else $error("settled too early");
  chk_bus_wait: assert property (req && !ack |-> waitrequest_out ##1 !waitrequest_out)
    else $error("bus answer not one wait cycle");
endmodule

// [sim/iosbt_tester.sv]
// Board tester model for the test, mode and functional input pins
`timescale 1ns/1ps
module iosbt_tester import iosbt_pkg::*; (
  input wire logic clock_in,
  input wire logic bck_pin_in,
  input wire logic bck_oe_in,
  input wire logic frm_pin_in,
  input wire logic frm_oe_in,
  input wire logic sf_pin_in,
  input wire logic sf_oe_in,
  output logic en_out,
  output logic sel0_out,
  output logic sel1_out,
  output logic nl_out,
  output logic drv_out,
  output logic csi_out,
  output logic dsi_out,
  output logic rst_n_out,
  output logic xtal_out,
  output logic bck_out,
  output logic frm_out,
  output logic sf_out
);
  logic [2:0] tim;
  // ****************************
  // Shared two-way timing pins
  // ****************************
  // Device wins the wire while its enable is high
  assign bck_out = bck_oe_in ? bck_pin_in : tim[0];
  assign frm_out = frm_oe_in ? frm_pin_in : tim[1];
  assign sf_out = sf_oe_in ? sf_pin_in : tim[2];
  // All pins low at time zero
  initial begin
    {en_out, sel0_out, sel1_out, nl_out, drv_out} = 5'h0;
    {tim, xtal_out, rst_n_out, dsi_out, csi_out} = 7'h0;
  end
  // ****************************
  // Pin vectors
  // ****************************
  // Apply one vector, then give the chain time to settle
  task automatic set_pins(input logic en, input logic [2:0] code, input logic drv, input logic [6:0] chain);
    @(posedge clock_in);
    en_out <= en;
    {sel0_out, sel1_out, nl_out} <= code;
    drv_out <= drv;
    {tim, xtal_out, rst_n_out, dsi_out, csi_out} <= chain;
    repeat (SETTLE_CYCLES) @(posedge clock_in);
  endtask
  // Seven clearing steps, one microsecond each, all else low
  task automatic run_init;
    logic [13:0] seq = {STEP1, STEP2, STEP3, STEP4, STEP5, STEP6, STEP7};
    for (int i = 0; i < 7; i++) begin
      set_pins(1'h0, 3'h0, 1'h0, {1'h0, seq[12-2*i], seq[13-2*i], 4'h0});
      repeat (25) @(posedge clock_in);
    end
    set_pins(1'h0, 3'h0, 1'h0, 7'h0);
  endtask
endmodule

// [sim/iosbt_top_tb.sv]
// Self-checking bench for the board connection test structure
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end
module iosbt_top_tb import iosbt_pkg::*; ;
  logic clock_in = 1'h0;
  logic nrst_in = 1'h0;
  logic [3:0] address_in = 4'h0;
  logic read_in = 1'h0;
  logic write_in = 1'h0;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic [8:0] norm = 9'h0;
  wire [13:0] outs;
  wire [11:0] pins;
  logic [31:0] rd;
  int err_total = 0;
  int n_tests = 0;
  logic [6:0] pats [10] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h03, 7'h55};
  // Clock generator
  always #4 clock_in = ~clock_in;
  iosbt_top uut (.clock_in, .nrst_in, .address_in, .read_in, .write_in, .writedata_in, .readdata_out,
    .waitrequest_out, .test_structure_enable_in(pins[P_EN]), .mode_select_bit0_in(pins[P_MS0]),
    .mode_select_bit1_in(pins[P_MS1]), .network_or_line_side_select_in(pins[P_NL]), .test_drive_in(pins[P_DRV]),
    .control_serial_in(pins[P_CSI]), .data_serial_in(pins[P_DSI]), .master_reset_n_in(pins[P_RST]),
    .crystal_in(pins[P_XTAL]), .bit_clock_io_in(pins[P_BCK]), .frame_pulse_io_in(pins[P_FRM]),
    .superframe_pulse_io_in(pins[P_SF]), .normal_data_serial_in(norm[8]), .normal_data_serial_oe_in(norm[7]),
    .normal_control_serial_in(norm[6]), .normal_control_serial_oe_in(norm[5]), .normal_frame_pulse_low_in(norm[4]),
    .normal_bit_clock_in(norm[3]), .normal_frame_pulse_in(norm[2]), .normal_superframe_in(norm[1]),
    .normal_timing_oe_in(norm[0]), .data_serial_out(outs[13]), .data_serial_oe_out(outs[12]),
    .control_serial_out(outs[11]), .control_serial_oe_out(outs[10]), .frame_pulse_open_drain_out(outs[9]),
    .frame_pulse_open_drain_oe_out(outs[8]), .parity_chain_out(outs[7]), .parity_chain_oe_out(outs[6]),
    .bit_clock_io_out(outs[5]), .bit_clock_io_oe_out(outs[4]), .frame_pulse_io_out(outs[3]),
    .frame_pulse_io_oe_out(outs[2]), .superframe_pulse_io_out(outs[1]), .superframe_pulse_io_oe_out(outs[0]));
  iosbt_tester tester (.clock_in, .bck_pin_in(outs[5]), .bck_oe_in(outs[4]), .frm_pin_in(outs[3]),
    .frm_oe_in(outs[2]), .sf_pin_in(outs[1]), .sf_oe_in(outs[0]), .en_out(pins[P_EN]), .sel0_out(pins[P_MS0]),
    .sel1_out(pins[P_MS1]), .nl_out(pins[P_NL]), .drv_out(pins[P_DRV]), .csi_out(pins[P_CSI]),
    .dsi_out(pins[P_DSI]), .rst_n_out(pins[P_RST]), .xtal_out(pins[P_XTAL]), .bck_out(pins[P_BCK]),
    .frm_out(pins[P_FRM]), .sf_out(pins[P_SF]));
  // ****************************
  // Expected pin pictures
  // ****************************
  // Normal path: core values pass, parity pin low and driven
  function automatic logic [13:0] exp_norm(input logic [8:0] n);
    return {n[8:5], 1'h0, n[4], 1'h0, 1'h1, n[3], n[0], n[2], n[0], n[1], n[0]};
  endfunction
  // Drive test: every pin follows d, open drain pulls low on 0
  function automatic logic [13:0] exp_drv(input logic d);
    return {d, 1'h1, d, 1'h1, 1'h0, ~d, d, 1'h1, d, 1'h1, d, 1'h1, d, 1'h1};
  endfunction
  // ****************************
  // Bus access and closing
  // ****************************
  // One Avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd_en, input logic [3:0] addr, input logic [31:0] wdata);
    logic done;
    done = 1'h0;
    @(posedge clock_in);
    address_in <= addr;
    writedata_in <= wdata;
    read_in <= rd_en;
    write_in <= ~rd_en;
    // Request stands until the answering edge; read data taken at that edge
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clock_in);
      done = (waitrequest_out === 1'h0);
      rd = readdata_out;
    end
    if (!done) begin
      err_total++;
      $display("BAD %0t bus answer missing", $time);
    end
    read_in <= 1'h0;
    write_in <= 1'h0;
  endtask
  // Counts, verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 4200 cycles
  initial begin
    repeat (60000) @(posedge clock_in);
    err_total++;
    stop_test();
  end
  // ****************************
  // Test sequence
  // ****************************
  initial begin
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'h1;
    // Register reset values, read-only and unmapped places
    bus(1'h1, REG_CTRL, 32'h0);
    `CHK(rd, {31'h0, CTRL_ALLOW_RESET})
    bus(1'h0, REG_STATUS, 32'h3f);
    bus(1'h1, REG_STATUS, 32'h0);
    `CHK({rd[STAT_SETTLED_BIT], rd[STAT_ARMED_BIT]}, 2'h2)
    bus(1'h1, 4'hc, 32'h0);
    `CHK(rd, 32'h0)
    $display("test registers done");
    // Test codes are refused before the clearing sequence
    tester.set_pins(1'h1, CODE_DRIVE, 1'h1, 7'h0);
    `CHK(outs, exp_norm(9'h0))
    bus(1'h1, REG_STATUS, 32'h0);
    `CHK(rd[2:1], MODE_OFF)
    tester.run_init();
    bus(1'h1, REG_STATUS, 32'h0);
    `CHK(rd[STAT_ARMED_BIT], 1'h1)
    $display("test arming done");
    // Parity chain over single ones, one pair and a mixed pattern
    for (int i = 0; i < 10; i++) begin
      tester.set_pins(1'h1, CODE_PARITY, 1'h0, pats[i]);
      `CHK({outs[7:6], outs[4], outs[2], outs[0]}, {^pats[i], 4'h8})
      bus(1'h1, REG_STATUS, 32'h0);
      `CHK({rd[STAT_ENABLE_BIT], rd[STAT_PARITY_BIT], rd[2:1]}, {1'h1, ^pats[i], MODE_PARITY})
    end
    bus(1'h1, REG_PINS, 32'h0);
    `CHK(rd[11:0], {7'h55, 5'h0b})
    $display("test parity done");
    // Forced drive, low, high and low again
    for (int i = 0; i < 3; i++) begin
      tester.set_pins(1'h1, CODE_DRIVE, i[0], 7'h2a);
      `CHK(outs, exp_drv(i[0]))
    end
    $display("test drive done");
    // Float: every enable low
    tester.set_pins(1'h1, CODE_HIZ, 1'h1, 7'h00);
    `CHK(outs & 14'h1555, 14'h0)
    bus(1'h1, REG_STATUS, 32'h0);
    `CHK(rd[2:1], MODE_HIZ)
    $display("test float done");
    // Enable low or an unused code leaves the core path alone
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_in);
      norm <= i[0] ? 9'h054 : 9'h1ab;
      tester.set_pins(1'h0, CODE_DRIVE, 1'h1, 7'h00);
      `CHK(outs, exp_norm(norm))
      tester.set_pins(1'h1, 3'h7, 1'h1, 7'h00);
      `CHK(outs, exp_norm(norm))
    end
    @(posedge clock_in);
    norm <= 9'h0;
    $display("test normal done");
    // Software block, clear of arming, and arming again
    bus(1'h0, REG_CTRL, 32'h0);
    tester.set_pins(1'h1, CODE_DRIVE, 1'h1, 7'h00);
    `CHK(outs, exp_norm(9'h0))
    bus(1'h0, REG_CTRL, 32'h3);
    bus(1'h1, REG_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    bus(1'h1, REG_STATUS, 32'h0);
    `CHK(rd[STAT_ARMED_BIT], 1'h0)
    `CHK(outs, exp_norm(9'h0))
    tester.run_init();
    tester.set_pins(1'h1, CODE_DRIVE, 1'h1, 7'h00);
    `CHK(outs, exp_drv(1'h1))
    $display("test rearm done");
    stop_test();
  end
endmodule
